// ---- verilog/acr_pkg.sv ----
package acr_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Configuration word layout
    localparam logic [15:0] CFG_RESET = 16'h8583; // Power-on value
    localparam int START_BIT = 15; // Single-shot start / status
    localparam int INSEL_LSB = 12; // Input select, 3 bits
    localparam int GAIN_LSB = 9; // Gain select, 3 bits
    localparam int MODE_BIT = 8; // 1 = power-down single-shot
    localparam int RATE_LSB = 5; // Rate select, 3 bits
    localparam int TEMP_BIT = 4; // Temperature sensor select
    localparam int PULLUP_BIT = 3; // Weak pull-up on data out
    localparam int QUAL_LSB = 1; // Write qualify, 2 bits
    localparam int RDY_BIT = 0; // Conversion ready, active low
    localparam logic [1:0] QUAL_VALID = 2'h1; // Only code that writes
    localparam int WORD_BITS = 16; // Bits per word
    localparam int FRAME_BITS = 32; // Result plus readback
    localparam logic [2:0] GAIN_MAX = 3'h5; // Codes above saturate here
    localparam logic [2:0] NEG_GROUND = 3'h4; // Negative input is ground

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CORE_CLK_HZ = 200_000_000; // Internal clock rate
    localparam int PRE_READY_CYCLES = 16; // Read must end this early
    localparam int SCLK_TIMEOUT_DEF = 65536; // Serial clock low timeout
    localparam int SCLK_HALF_DEF = 8; // Host half period in cycles
    localparam int SCLK_HALF_MIN = 8; // Covers both synchronisers

    ////////////////////////////////////////////////////////////////////////////
    // Host controller register offsets
    localparam logic [7:0] REG_CMD = 8'h00; // Write launches frame
    localparam logic [7:0] REG_STATUS = 8'h04; // Busy, data ready
    localparam logic [7:0] REG_RESULT = 8'h08; // Last result
    localparam logic [7:0] REG_CONFIG = 8'h0c; // Last readback
    localparam logic [7:0] REG_CTRL = 8'h10; // Auto read enable
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_READY_BIT = 1;
    localparam int CTRL_AUTO_BIT = 0;

    // Samples per second for each rate code
    function automatic int rate_sps(input logic [2:0] code);
        case (code)
            3'h0: rate_sps = 8;
            3'h1: rate_sps = 16;
            3'h2: rate_sps = 32;
            3'h3: rate_sps = 64;
            3'h4: rate_sps = 128;
            3'h5: rate_sps = 250;
            3'h6: rate_sps = 475;
            default: rate_sps = 860;
        endcase
    endfunction : rate_sps

endpackage : acr_pkg

// ---- verilog/acr_link_if.sv ----
`timescale 1ns/1ps
// Serial link between host controller and converter
interface acr_link_if;
    logic cs_n; // Chip select, low active
    logic sclk; // Serial clock from host
    logic mosi; // Host to converter data
    logic miso; // Converter output value
    logic miso_oe; // Converter drives the line
    logic miso_pu; // Weak pull-up enabled
    logic miso_line; // Resolved line level

    // Undriven line goes to the pull-up level if enabled, else shows the
    // inverse of the last value so a host sampling a floating line is caught
    assign miso_line = miso_oe ? miso : (miso_pu ? 1'b1 : ~miso);

    modport dev (
        input cs_n,
        input sclk,
        input mosi,
        output miso,
        output miso_oe,
        output miso_pu
    );

    modport host (
        output cs_n,
        output sclk,
        output mosi,
        input miso_line
    );
endinterface : acr_link_if

// ---- verilog/acr_dev.sv ----
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/1ps
module acr_dev #(
    parameter int CLK_HZ = acr_pkg::CORE_CLK_HZ,
    parameter int SCLK_TIMEOUT = acr_pkg::SCLK_TIMEOUT_DEF,
    parameter int CNT_W = 26
) (
    input wire logic core_clk,
    input wire logic rst,
    acr_link_if.dev link,
    input wire logic [15:0] sample_in,
    output logic [15:0] config_word,
    output logic [15:0] result_word,
    output logic conv_busy,
    output logic conv_done,
    output logic [1:0] pos_input,
    output logic [2:0] neg_input,
    output logic [2:0] range_select,
    output logic temp_sensor_select
);
    import acr_pkg::*;

    localparam int TO_W = $clog2(SCLK_TIMEOUT + 1);

    ////////////////////////////////////////////////////////////////////////////
    // Parameter checks
    generate
        if (CLK_HZ / 8 >= (2 ** CNT_W) || CNT_W > 31) begin : g_bad_cnt
            $error("Conversion counter too narrow for slowest rate");
        end
        if (CLK_HZ / 860 <= PRE_READY_CYCLES + 2) begin : g_bad_clk
            $error("Fastest conversion shorter than ready lead time");
        end
        if (SCLK_TIMEOUT < 2) begin : g_bad_to
            $error("Serial clock timeout too short");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Types and state
    typedef enum logic [1:0] {
        ACR_CV_IDLE = 2'b00, // Powered down
        ACR_CV_RUN = 2'b01 // Converting
    } acr_conv_t;

    typedef struct packed {
        logic cs_s1; // Chip select synchroniser
        logic cs_s2;
        logic sclk_s1; // Serial clock synchroniser
        logic sclk_s2;
        logic sclk_s3; // Edge detector history
        logic din_s1; // Serial input synchroniser
        logic din_s2;
        logic [15:0] cfg; // Stored configuration
        logic [15:0] result; // Conversion result
        logic busy; // Conversion in progress
        logic ready_n; // Ready flag, low active
        acr_conv_t st; // Converter state
        logic [CNT_W-1:0] cnt; // Conversion timer
        logic [CNT_W-1:0] len; // Period latched at start
        logic [5:0] bit_cnt; // Falling edges in frame
        logic [FRAME_BITS-1:0] tx; // Outgoing shift register
        logic [WORD_BITS-1:0] rx; // Incoming config word
        logic [TO_W-1:0] to_cnt; // Clock-low timer
        logic dout; // Output line value
        logic oe; // Output enable
        logic done; // Result loaded pulse
        logic [1:0] pos; // Decoded positive input
        logic [2:0] neg; // Decoded negative input
        logic [2:0] rng; // Effective range code
    } acr_dev_state_t;

    acr_dev_state_t s_reg;
    acr_dev_state_t s_next;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Cycles per conversion at the chosen rate
    function automatic logic [CNT_W-1:0] conv_cycles(input logic [2:0] code);
        conv_cycles = CNT_W'(CLK_HZ / rate_sps(code));
    endfunction : conv_cycles

    // Readback view: status and flag bits reflect live state
    function automatic logic [15:0] cfg_view(input acr_dev_state_t s);
        cfg_view = s.cfg;
        cfg_view[START_BIT] = ~s.busy;
        cfg_view[QUAL_LSB +: 2] = QUAL_VALID;
        cfg_view[RDY_BIT] = s.ready_n;
    endfunction : cfg_view

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        logic rise;
        logic fall;
        logic start_req;
        logic [15:0] wword;
        logic [FRAME_BITS-1:0] word;
        logic [2:0] isel;
        rise = 1'b0;
        fall = 1'b0;
        start_req = 1'b0;
        wword = '0;
        word = '0;
        isel = '0;
        s_next = s_reg;
        s_next.done = 1'b0;

        // Pins pass two flip-flops before use
        s_next.cs_s1 = link.cs_n;
        s_next.cs_s2 = s_reg.cs_s1;
        s_next.sclk_s1 = link.sclk;
        s_next.sclk_s2 = s_reg.sclk_s1;
        s_next.sclk_s3 = s_reg.sclk_s2;
        s_next.din_s1 = link.mosi;
        s_next.din_s2 = s_reg.din_s1;

        if (s_reg.cs_s2) begin
            // Deselected: clock ignored, link state cleared
            s_next.bit_cnt = '0;
            s_next.to_cnt = '0;
            s_next.oe = 1'b0;
            s_next.dout = 1'b1;
        end else begin
            s_next.oe = 1'b1;
            rise = s_reg.sclk_s2 & ~s_reg.sclk_s3;
            fall = ~s_reg.sclk_s2 & s_reg.sclk_s3;

            // Clock-low watchdog restarts the frame
            if (s_reg.sclk_s2) begin
                s_next.to_cnt = '0;
            end else if (s_reg.to_cnt == TO_W'(SCLK_TIMEOUT - 1)) begin
                s_next.to_cnt = '0;
                s_next.bit_cnt = '0;
            end else begin
                s_next.to_cnt = s_reg.to_cnt + 1'b1;
            end

            if (rise && s_reg.bit_cnt < 6'(FRAME_BITS)) begin
                // Snapshot is taken on the first rise so the frame is coherent
                word = (s_reg.bit_cnt == '0) ? {s_reg.result, cfg_view(s_reg)} : s_reg.tx;
                s_next.dout = word[FRAME_BITS-1];
                s_next.tx = {word[FRAME_BITS-2:0], 1'b0};
            end else if (!s_reg.sclk_s2 && (s_reg.bit_cnt == '0 || s_reg.bit_cnt == 6'(FRAME_BITS))) begin
                // Between frames the line carries the ready indication in continuous mode and
                // sits high in single-shot; a high clock with no fall yet means bit 15 is still on show
                if (!s_reg.cfg[MODE_BIT]) begin
                    s_next.dout = s_reg.ready_n;
                end else begin
                    s_next.dout = 1'b1;
                end
            end

            if (fall && s_reg.bit_cnt < 6'(FRAME_BITS)) begin
                s_next.bit_cnt = s_reg.bit_cnt + 1'b1;
                if (s_reg.bit_cnt < 6'(WORD_BITS)) begin
                    s_next.rx = {s_reg.rx[WORD_BITS-2:0], s_reg.din_s2};
                end
                if (s_reg.bit_cnt == 6'(WORD_BITS - 1)) begin
                    wword = {s_reg.rx[WORD_BITS-2:0], s_reg.din_s2};
                    if (wword[QUAL_LSB +: 2] == QUAL_VALID) begin
                        // Stored bits are everything but status and flags
                        s_next.cfg = {1'b0, wword[14:3], QUAL_VALID, 1'b0};
                        // Start honoured only while powered down and idle
                        start_req = wword[START_BIT] & s_reg.cfg[MODE_BIT] & ~s_reg.busy;
                    end
                end
            end
        end

        // Conversion engine
        case (s_reg.st)
            ACR_CV_IDLE: begin
                // Continuous mode starts by itself; single-shot waits
                if (start_req || !s_next.cfg[MODE_BIT]) begin
                    s_next.st = ACR_CV_RUN;
                    s_next.busy = 1'b1;
                    s_next.ready_n = 1'b1;
                    s_next.cnt = '0;
                    s_next.len = conv_cycles(s_next.cfg[RATE_LSB +: 3]);
                end
            end
            ACR_CV_RUN: begin
                if (s_reg.cnt == s_reg.len - 1'b1) begin
                    s_next.result = sample_in;
                    s_next.done = 1'b1;
                    s_next.ready_n = 1'b0;
                    // Rearm the frame so a held-low select can read again
                    if (s_reg.bit_cnt == 6'(FRAME_BITS)) begin
                        s_next.bit_cnt = '0;
                    end
                    if (!s_next.cfg[MODE_BIT]) begin
                        s_next.cnt = '0;
                        s_next.len = conv_cycles(s_next.cfg[RATE_LSB +: 3]);
                    end else begin
                        s_next.st = ACR_CV_IDLE;
                        s_next.busy = 1'b0;
                    end
                end else begin
                    s_next.cnt = s_reg.cnt + 1'b1;
                    // Line returns high ahead of the next ready edge
                    if (!s_reg.cfg[MODE_BIT] && s_reg.cnt == s_reg.len - CNT_W'(PRE_READY_CYCLES + 1)) begin
                        s_next.ready_n = 1'b1;
                    end
                end
            end
            default: begin
                s_next.st = ACR_CV_IDLE;
                s_next.busy = 1'b0;
            end
        endcase

        // Front-end routing decode
        isel = s_next.cfg[INSEL_LSB +: 3];
        if (isel[2]) begin
            s_next.pos = isel[1:0];
            s_next.neg = NEG_GROUND;
        end else begin
            s_next.pos = (isel == 3'h0 || isel == 3'h1) ? 2'h0 : (isel == 3'h2 ? 2'h1 : 2'h2);
            s_next.neg = (isel == 3'h0) ? 3'h1 : 3'h3;
        end
        // Codes above the smallest range all map to it
        if (s_next.cfg[GAIN_LSB +: 3] > GAIN_MAX) begin
            s_next.rng = GAIN_MAX;
        end else begin
            s_next.rng = s_next.cfg[GAIN_LSB +: 3];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
            s_reg.cs_s1 <= 1'b1;
            s_reg.cs_s2 <= 1'b1;
            s_reg.cfg <= {1'b0, CFG_RESET[14:1], 1'b0};
            s_reg.ready_n <= 1'b1;
            s_reg.dout <= 1'b1;
            s_reg.neg <= 3'h1;
            s_reg.rng <= CFG_RESET[GAIN_LSB +: 3];
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all from flip-flops
    assign link.miso = s_reg.dout;
    assign link.miso_oe = s_reg.oe;
    assign link.miso_pu = s_reg.cfg[PULLUP_BIT];
    assign config_word = cfg_view(s_reg);
    assign result_word = s_reg.result;
    assign conv_busy = s_reg.busy;
    assign conv_done = s_reg.done;
    assign pos_input = s_reg.pos;
    assign neg_input = s_reg.neg;
    assign range_select = s_reg.rng;
    assign temp_sensor_select = s_reg.cfg[TEMP_BIT];

endmodule : acr_dev

// ---- verilog/acr_host.sv ----
`timescale 1ns/1ps
// Host controller: register port on one side, serial link on the other
module acr_host #(
    parameter int SCLK_HALF = acr_pkg::SCLK_HALF_DEF
) (
    input wire logic core_clk,
    input wire logic rst,
    acr_link_if.host link,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata
);
    import acr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Parameter checks
    generate
        if (SCLK_HALF < SCLK_HALF_MIN || SCLK_HALF > 255) begin : g_bad_half
            $error("Serial half period outside supported range");
        end
    endgenerate

    typedef enum logic [1:0] {
        ACR_H_IDLE = 2'b00, // Waiting for work
        ACR_H_LEAD = 2'b01, // Select set up
        ACR_H_SHIFT = 2'b11, // Clocking 32 bits
        ACR_H_TAIL = 2'b10 // Hold before release
    } acr_host_st_t;

    typedef struct packed {
        acr_host_st_t st; // Frame state
        logic [7:0] half; // Half-period divider
        logic [5:0] bit_cnt; // Bits received
        logic [WORD_BITS-1:0] tx; // Outgoing word
        logic [FRAME_BITS-1:0] rx; // Incoming frame
        logic cs_n; // Select output
        logic sclk; // Serial clock output
        logic mosi; // Data output
        logic miso_s1; // Line synchroniser
        logic miso_s2;
        logic miso_s3; // Ready edge history
        logic auto; // Auto read in continuous mode
        logic [15:0] result; // Last result
        logic [15:0] cfg; // Last readback
        logic [31:0] rdata; // Read data, one cycle late
    } acr_host_state_t;

    acr_host_state_t s_reg;
    acr_host_state_t s_next;

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        logic tick;
        tick = (s_reg.half == 8'(SCLK_HALF - 1));
        s_next = s_reg;
        s_next.miso_s1 = link.miso_line;
        s_next.miso_s2 = s_reg.miso_s1;
        s_next.miso_s3 = s_reg.miso_s2;
        s_next.half = tick ? '0 : s_reg.half + 1'b1;

        // Register reads: data valid only in the following cycle
        s_next.rdata = '0;
        if (rd) begin
            case (addr)
                REG_STATUS: begin
                    s_next.rdata[STAT_BUSY_BIT] = (s_reg.st != ACR_H_IDLE);
                    s_next.rdata[STAT_READY_BIT] = ~s_reg.cs_n & ~s_reg.miso_s2;
                end
                REG_RESULT: s_next.rdata = {16'h0000, s_reg.result};
                REG_CONFIG: s_next.rdata = {16'h0000, s_reg.cfg};
                REG_CTRL: s_next.rdata[CTRL_AUTO_BIT] = s_reg.auto;
                default: s_next.rdata = '0;
            endcase
        end
        if (wr && addr == REG_CTRL) begin
            s_next.auto = wdata[CTRL_AUTO_BIT];
        end

        case (s_reg.st)
            ACR_H_IDLE: begin
                // Select stays low in auto mode so ready can be seen
                s_next.cs_n = ~s_next.auto;
                s_next.sclk = 1'b0;
                if (wr && addr == REG_CMD) begin
                    // Start bit write then a later read fetches the result
                    s_next.tx = wdata[15:0];
                    s_next.st = ACR_H_LEAD;
                    s_next.half = '0;
                    s_next.cs_n = 1'b0;
                end else if (s_reg.auto && !s_reg.cs_n && s_reg.miso_s3 && !s_reg.miso_s2) begin
                    // Falling line only: one read per result, done long before the next
                    // All ones: qualify code 11 leaves config alone
                    s_next.tx = 16'hffff;
                    s_next.st = ACR_H_LEAD;
                    s_next.half = '0;
                end
            end
            ACR_H_LEAD: begin
                s_next.bit_cnt = '0;
                if (tick) begin
                    s_next.st = ACR_H_SHIFT;
                end
            end
            ACR_H_SHIFT: begin
                if (tick && !s_reg.sclk) begin
                    // Data changes on the rise, stable at the fall
                    s_next.sclk = 1'b1;
                    s_next.mosi = s_reg.tx[WORD_BITS-1];
                    s_next.tx = {s_reg.tx[WORD_BITS-2:0], 1'b1};
                end else if (tick) begin
                    s_next.sclk = 1'b0;
                    s_next.rx = {s_reg.rx[FRAME_BITS-2:0], s_reg.miso_s2};
                    s_next.bit_cnt = s_reg.bit_cnt + 1'b1;
                    if (s_reg.bit_cnt == 6'(FRAME_BITS - 1)) begin
                        s_next.result = s_reg.rx[FRAME_BITS-2:WORD_BITS-1];
                        s_next.cfg = {s_reg.rx[WORD_BITS-2:0], s_reg.miso_s2};
                        s_next.st = ACR_H_TAIL;
                    end
                end
            end
            ACR_H_TAIL: begin
                if (tick) begin
                    s_next.cs_n = ~s_reg.auto;
                    s_next.st = ACR_H_IDLE;
                end
            end
            default: s_next.st = ACR_H_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
            s_reg.cs_n <= 1'b1;
            s_reg.mosi <= 1'b1;
            s_reg.miso_s1 <= 1'b1;
            s_reg.miso_s2 <= 1'b1;
            s_reg.miso_s3 <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign link.cs_n = s_reg.cs_n;
    assign link.sclk = s_reg.sclk;
    assign link.mosi = s_reg.mosi;
    assign rdata = s_reg.rdata;

endmodule : acr_host

// ---- sim/acr_link_monitor.sv ----
`timescale 1ns/1ps
// Watches the serial link where both ends are design code
module acr_link_monitor (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe,
    input wire logic miso_pu,
    input wire logic miso_line
);
    logic [4:0] rise_cnt_reg; // Rises in frame, wraps each frame
    logic [3:0] hold_reg; // Cycles since sclk last moved
    logic sclk_d_reg; // Delayed clock for edge finding
    logic [4:0] sel_age_reg; // Cycles selected, saturating
    ////////////////////////////////////////////////////////////
    // Helper counters; frame count cleared while deselected
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rise_cnt_reg <= 5'h0;
            hold_reg <= 4'h0;
            sclk_d_reg <= 1'b0;
            sel_age_reg <= 5'h0;
        end else begin
            sel_age_reg <= cs_n ? 5'h0 : sel_age_reg + 5'(sel_age_reg != 5'h1f);
            sclk_d_reg <= sclk;
            rise_cnt_reg <= cs_n ? 5'h0 : rise_cnt_reg + 5'(sclk & ~sclk_d_reg);
            // Saturate so long idle gaps never wrap
            hold_reg <= (sclk != sclk_d_reg) ? 4'h0 : hold_reg + 4'(hold_reg != 4'hf);
        end
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    a_float_desel: assert property (cs_n [*4] |-> !miso_oe)
        else $error("data out driven while deselected");
    a_sclk_idle: assert property (cs_n && $past(cs_n) |-> !sclk)
        else $error("serial clock moves while deselected");
    a_mosi_stable: assert property ($fell(sclk) |-> $stable(mosi))
        else $error("host data moved at falling clock");
    a_sclk_spacing: assert property ($changed(sclk) |-> hold_reg >= 4'h6)
        else $error("serial clock half period too short");
    a_miso_hold: assert property (!cs_n && $fell(sclk) |-> $stable(miso) [*3])
        else $error("device data moved near falling clock");
    a_frame_len: assert property ($rose(cs_n) |-> rise_cnt_reg == 5'h0)
        else $error("frame not a whole 32 clocks");
    a_lead_in: assert property ($rose(sclk) && rise_cnt_reg == 5'h0 |-> !cs_n && sel_age_reg >= 5'h0e)
        else $error("frame start lead wrong");
    a_drive_sel: assert property (!cs_n [*6] |-> miso_oe)
        else $error("device not driving while selected");
endmodule : acr_link_monitor

// ---- sim/tb_adc_config_and_data_readout.sv ----
`timescale 1ns/1ps
module tb_adc_config_and_data_readout;
    import acr_pkg::*;
    typedef struct packed {
        logic [15:0] word;
        logic [15:0] readback;
        logic [15:0] route; // {pos, neg, range, temp, pull-up}
    } acr_row_t;
    // Config writes with each qualify code, then expected readback and routing
    localparam acr_row_t ROWS [7] = '{'{16'h5ffa, 16'hdffb, 16'h0197}, '{16'h0004, 16'hdffb, 16'h0197},
        '{16'h0000, 16'hdffb, 16'h0197}, '{16'hffff, 16'hdffb, 16'h0197}, '{16'h2702, 16'ha703, 16'h016c},
        '{16'h3902, 16'hb903, 16'h0270}, '{16'h0102, 16'h8103, 16'h0020}};
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic [15:0] sample_in = 16'h0; // Analog value seen by converter
    logic [31:0] got; // Last register read
    logic conv_done; // Result loaded pulse
    logic [1:0] pos_input; // Front-end routing seen
    logic [2:0] neg_input;
    logic [2:0] range_select;
    logic temp_sensor_select;
    int dones = 0; // Conversions counted
    int fails = 0;
    int compares = 0;
    acr_link_if link();
    // Short conversion periods and timeout keep the run brief
    acr_dev #(.CLK_HZ(200000), .SCLK_TIMEOUT(64)) acr_dev_i (.core_clk(core_clk), .rst(rst), .link(link),
        .sample_in(sample_in), .config_word(), .result_word(), .conv_busy(), .conv_done(conv_done),
        .pos_input(pos_input), .neg_input(neg_input), .range_select(range_select),
        .temp_sensor_select(temp_sensor_select));
    acr_host acr_host_i (.core_clk(core_clk), .rst(rst), .link(link), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata));
    acr_link_monitor acr_link_monitor_i (.core_clk(core_clk), .rst(rst), .cs_n(link.cs_n), .sclk(link.sclk),
        .mosi(link.mosi), .miso(link.miso), .miso_oe(link.miso_oe), .miso_pu(link.miso_pu),
        .miso_line(link.miso_line));
    always #2.5 core_clk = ~core_clk;
    // Count loads so a start is seen to launch exactly one conversion
    always @(posedge core_clk) begin
        if (conv_done === 1'b1) begin
            dones <= dones + 1;
        end
    end
    ////////////////////////////////////////////////////////////
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge core_clk);
        wr <= 1'b0;
    endtask : wr_reg
    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a);
        @(posedge core_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge core_clk);
        rd <= 1'b0;
        #1 got = rdata;
    endtask : rd_reg
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic print_verdict();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict
    // Launch one frame and wait for the host to finish it
    task automatic frame(input logic [15:0] w);
        int n;
        wr_reg(REG_CMD, {16'h0, w});
        repeat (4) @(posedge core_clk);
        for (n = 0; n < 600; n++) begin
            rd_reg(REG_STATUS);
            if (got[STAT_BUSY_BIT] === 1'b0) break;
        end
        if (n == 600) begin
            fails++;
            print_verdict();
        end
    endtask : frame
    ////////////////////////////////////////////////////////////
    // Hang guard
    initial begin
        repeat (60000) @(posedge core_clk);
        fails++;
        print_verdict();
    end
    initial begin
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        frame(16'h0000);
        rd_reg(REG_CONFIG);
        check("reset config", got[15:0], 16'h8583);
        rd_reg(REG_RESULT);
        check("reset result", got[15:0], 16'h0000);
        $display("test reset done");
        // A no-write frame after each row shows the stored word
        foreach (ROWS[i]) begin
            frame(ROWS[i].word);
            frame(16'h0000);
            rd_reg(REG_CONFIG);
            check("row readback", got[15:0], ROWS[i].readback);
            check("row routing", {6'h0, pos_input, neg_input, range_select, temp_sensor_select, link.miso_pu},
                ROWS[i].route);
        end
        $display("test rows done");
        // One shot at 250 per second: busy seen in the next frame
        @(posedge core_clk);
        sample_in <= 16'h1234;
        frame(16'h85a2);
        frame(16'h0000);
        rd_reg(REG_CONFIG);
        check("busy readback", got[15:0], 16'h05a3);
        repeat (600) @(posedge core_clk);
        frame(16'h0000);
        rd_reg(REG_CONFIG);
        check("done readback", got[15:0], 16'h85a2);
        rd_reg(REG_RESULT);
        check("one shot result", got[15:0], 16'h1234);
        check("one conversion", 16'(dones), 16'h0001);
        @(posedge core_clk);
        sample_in <= 16'h5678;
        frame(16'h0000);
        rd_reg(REG_RESULT);
        check("held result", got[15:0], 16'h1234);
        $display("test single shot done");
        // Continuous mode, host reads on the falling data line
        frame(16'h0482);
        wr_reg(REG_CTRL, 32'h1);
        repeat (4000) @(posedge core_clk);
        rd_reg(REG_RESULT);
        check("continuous result", got[15:0], 16'h5678);
        rd_reg(REG_CONFIG);
        check("continuous readback", got[15:0], 16'h0482);
        $display("test continuous done");
        print_verdict();
    end
endmodule : tb_adc_config_and_data_readout
